// File: sdbt_top.sv
// Card block-transfer engine: data FIFO, block sequencing, DMA kick and status over APB.
// Assumes a 200 MHz pclk, a link clock and data line arriving from outside the clock domain.
`timescale 1ns/1ps
`include "sdbt_consts.svh"

module sdbt_top import sdbt_pkg::*; #(
  parameter int FIFO_AW = `SDBT_FIFO_AW
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic dma_req,
  output logic mem_clk,
  input wire logic link_clk,
  input wire logic card_dat_i,
  output logic card_dat_o,
  output logic card_dat_oe
);

  localparam logic [7:0] MIN_DIV = 8'(`SDBT_MEMCLK_MIN_DIV);
  localparam logic [FIFO_AW:0] DEPTH = (FIFO_AW+1)'(1 << FIFO_AW);

  initial begin
    if (FIFO_AW != `SDBT_FIFO_AW) begin
      $error("sdbt_top: FIFO_AW must match the state record pointer width");
    end
  end

  sdbt_state_t s_ff;
  sdbt_state_t nxt_s;
  sdbt_apb_req_t req;
  logic [31:0] mem_rdata;
  logic mem_we;
  logic mem_re;
  logic [FIFO_AW-1:0] mem_raddr;
  logic [31:0] mem_wdata;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  sdbt_fifo_mem #(
    .AW(FIFO_AW),
    .DW(32)
  ) u_mem (
    .pclk(pclk),
    .we(mem_we),
    .waddr(s_ff.wr_ptr[FIFO_AW-1:0]),
    .wdata(mem_wdata),
    .re(mem_re),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // ==============================================================
  // Next-state logic
  logic [FIFO_AW:0] fill;
  logic [4:0] thr_words;
  logic tx_dir;
  logic empty;
  logic full;
  logic rx_lvl;
  logic tx_lvl;
  logic lrise;
  logic lfall;
  logic acc;
  logic setup_rd;
  logic apb_re;
  logic link_re;
  logic blk_end;
  logic [15:0] blk_next;
  logic xfer_done;
  logic [18:0] last_bit;
  logic [7:0] eff_div;
  logic [3:0] st_set;
  logic [3:0] st_clr;

  always_comb begin
    nxt_s = s_ff;
    fill = s_ff.wr_ptr - s_ff.rd_ptr;
    tx_dir = s_ff.fifo_ctl[`SDBT_FC_DIR];
    thr_words = s_ff.fifo_ctl[`SDBT_FC_THR] ? `SDBT_THR1_WORDS : `SDBT_THR0_WORDS;
    empty = (fill == '0);
    full = (fill == DEPTH);
    rx_lvl = !tx_dir && ({{(5-FIFO_AW){1'b0}}, fill[FIFO_AW-1:0]} >= thr_words || full);
    tx_lvl = tx_dir && (5'(DEPTH - fill) >= thr_words);
    lrise = s_ff.lclk_s2 && !s_ff.lclk_prev;
    lfall = !s_ff.lclk_s2 && s_ff.lclk_prev;
    acc = req.psel && req.penable && !s_ff.pready;
    setup_rd = req.psel && !req.penable && !req.pwrite && req.paddr == `SDBT_RXDATA_OFS;
    apb_re = setup_rd && !tx_dir && !empty;
    link_re = tx_dir && !apb_re && !empty && !s_ff.txw_valid && !s_ff.txw_pend &&
              (s_ff.lstate == SDBT_L_TX_START || s_ff.lstate == SDBT_L_TX_DATA);
    mem_re = apb_re || link_re;
    mem_raddr = s_ff.rd_ptr[FIFO_AW-1:0];
    mem_we = 1'b0;
    mem_wdata = req.pwdata;
    blk_end = 1'b0;
    xfer_done = 1'b0;
    blk_next = s_ff.blk_done + 16'h0001;
    last_bit = {s_ff.blen, 3'h0} - 19'h00001;
    st_set = '0;
    st_clr = '0;

    // Synchronisers: first stage feeds only the second
    nxt_s.lclk_s1 = link_clk;
    nxt_s.lclk_s2 = s_ff.lclk_s1;
    nxt_s.lclk_prev = s_ff.lclk_s2;
    nxt_s.dat_s1 = card_dat_i;
    nxt_s.dat_s2 = s_ff.dat_s1;

    // ==============================================================
    // FIFO read side
    if (mem_re) begin
      nxt_s.rd_ptr = s_ff.rd_ptr + 1'b1;
    end
    nxt_s.apb_rd_pend = apb_re;
    nxt_s.txw_pend = link_re;
    if (s_ff.txw_pend) begin
      nxt_s.shreg = mem_rdata;
      nxt_s.txw_valid = 1'b1;
    end

    // ==============================================================
    // APB slave: one wait state, answer registered
    nxt_s.pready = acc;
    nxt_s.pslverr = 1'b0;
    if (acc) begin
      nxt_s.prdata = '0;
      if (req.paddr == `SDBT_FIFO_CTL_OFS) begin
        nxt_s.prdata = {27'h0, s_ff.fifo_ctl};
        if (req.pwrite) nxt_s.fifo_ctl = req.pwdata[4:0];
      end else if (req.paddr == `SDBT_MEMCLK_OFS) begin
        nxt_s.prdata = {23'h0, s_ff.clk_en, s_ff.clk_div};
        if (req.pwrite) begin
          nxt_s.clk_div = req.pwdata[7:0];
          nxt_s.clk_en = req.pwdata[`SDBT_MC_EN];
        end
      end else if (req.paddr == `SDBT_PSTAT_OFS) begin
        nxt_s.prdata = {28'h0, s_ff.status};
        if (!req.pwrite) st_clr = s_ff.status;
      end else if (req.paddr == `SDBT_SSTAT_OFS) begin
        nxt_s.prdata = {27'h0, s_ff.unr, s_ff.ovr, s_ff.lstate != SDBT_L_IDLE, full, empty};
      end else if (req.paddr == `SDBT_MASK_OFS) begin
        nxt_s.prdata = {28'h0, s_ff.mask};
        if (req.pwrite) nxt_s.mask = req.pwdata[3:0];
      end else if (req.paddr == `SDBT_BLEN_OFS) begin
        nxt_s.prdata = {16'h0, s_ff.blen};
        if (req.pwrite) nxt_s.blen = req.pwdata[15:0];
      end else if (req.paddr == `SDBT_NBLK_OFS) begin
        nxt_s.prdata = {16'h0, s_ff.nblk};
        if (req.pwrite) nxt_s.nblk = req.pwdata[15:0];
      end else if (req.paddr == `SDBT_BDONE_OFS) begin
        nxt_s.prdata = {16'h0, s_ff.blk_done};
      end else if (req.paddr == `SDBT_RXDATA_OFS) begin
        nxt_s.prdata = s_ff.apb_rd_pend ? mem_rdata : 32'h0;
      end else if (req.paddr == `SDBT_TXDATA_OFS) begin
        if (req.pwrite && tx_dir && !full) begin
          mem_we = 1'b1;
        end else if (req.pwrite && tx_dir) begin
          nxt_s.ovr = 1'b1;
        end
      end else if (req.paddr == `SDBT_CMDLO_OFS) begin
        nxt_s.prdata = {26'h0, s_ff.cmd_idx};
        if (req.pwrite) begin
          nxt_s.cmd_idx = req.pwdata[5:0];
          if (req.pwdata[5:0] == `SDBT_STOP_IDX) begin
            // Explicit stop ends an open-ended transfer
            if (s_ff.lstate != SDBT_L_IDLE) xfer_done = 1'b1;
          end else if (req.pwdata[`SDBT_CL_DATA]) begin
            nxt_s.blk_done = '0;
            nxt_s.bitcnt = '0;
            nxt_s.lstate = tx_dir ? SDBT_L_TX_START : SDBT_L_RX_START;
            nxt_s.dma_act = s_ff.dma_mode && !tx_dir;
          end
        end
      end else if (req.paddr == `SDBT_CMDHI_OFS) begin
        nxt_s.prdata = {31'h0, s_ff.dma_mode};
        if (req.pwrite) begin
          nxt_s.dma_mode = req.pwdata[`SDBT_CH_DMAMODE];
          if (req.pwdata[`SDBT_CH_KICK] && tx_dir) nxt_s.dma_act = 1'b1;
        end
      end else if (req.paddr == `SDBT_ARGLO_OFS) begin
        nxt_s.prdata = {16'h0, s_ff.arg_lo};
        if (req.pwrite) nxt_s.arg_lo = req.pwdata[15:0];
      end else if (req.paddr == `SDBT_ARGHI_OFS) begin
        nxt_s.prdata = {16'h0, s_ff.arg_hi};
        if (req.pwrite) nxt_s.arg_hi = req.pwdata[15:0];
      end else begin
        nxt_s.pslverr = 1'b1;
      end
    end

    // ==============================================================
    // Link sequencer; any block length that is a whole number of words works
    case (s_ff.lstate)
      SDBT_L_RX_START: begin
        if (lrise && !s_ff.dat_s2) begin
          nxt_s.lstate = SDBT_L_RX_DATA;
          nxt_s.bitcnt = '0;
        end
      end
      SDBT_L_RX_DATA: begin
        if (lrise) begin
          nxt_s.shreg = {s_ff.shreg[30:0], s_ff.dat_s2};
          nxt_s.bitcnt = s_ff.bitcnt + 19'h00001;
          if (s_ff.bitcnt[4:0] == 5'h1f) begin
            mem_wdata = {s_ff.shreg[30:0], s_ff.dat_s2};
            // Overrun drops the word rather than corrupt older data
            if (full) nxt_s.ovr = 1'b1;
            else mem_we = 1'b1;
          end
          if (s_ff.bitcnt == last_bit) blk_end = 1'b1;
        end
      end
      SDBT_L_TX_START: begin
        if (lfall && s_ff.txw_valid) begin
          nxt_s.dat_o = 1'b0;
          nxt_s.dat_oe = 1'b1;
          nxt_s.bitcnt = '0;
          nxt_s.lstate = SDBT_L_TX_DATA;
        end
      end
      SDBT_L_TX_DATA: begin
        if (lfall && s_ff.txw_valid) begin
          nxt_s.dat_o = s_ff.shreg[31];
          nxt_s.shreg = {s_ff.shreg[30:0], 1'b0};
          nxt_s.bitcnt = s_ff.bitcnt + 19'h00001;
          if (s_ff.bitcnt[4:0] == 5'h1f) nxt_s.txw_valid = 1'b0;
          if (s_ff.bitcnt == last_bit) nxt_s.lstate = SDBT_L_TX_END;
        end else if (lfall) begin
          // Link clock cannot be held, so a starved bit is flagged
          nxt_s.unr = 1'b1;
        end
      end
      SDBT_L_TX_END: begin
        if (lfall) begin
          nxt_s.dat_o = 1'b1;
          blk_end = 1'b1;
        end
      end
      default: begin
        if (lfall) nxt_s.dat_oe = 1'b0;
      end
    endcase

    if (blk_end) begin
      nxt_s.blk_done = blk_next;
      nxt_s.lstate = tx_dir ? SDBT_L_TX_START : SDBT_L_RX_START;
      if (s_ff.nblk != '0 && blk_next == s_ff.nblk) xfer_done = 1'b1;
    end
    if (xfer_done) begin
      nxt_s.lstate = SDBT_L_IDLE;
      nxt_s.dma_act = 1'b0;
      st_set[`SDBT_ST_DONE] = 1'b1;
    end

    if (mem_we) nxt_s.wr_ptr = s_ff.wr_ptr + 1'b1;

    // Flush overrides every pointer update while held
    if (s_ff.fifo_ctl[`SDBT_FC_FLUSH]) begin
      mem_we = 1'b0;
      nxt_s.wr_ptr = '0;
      nxt_s.rd_ptr = '0;
      nxt_s.txw_valid = 1'b0;
      nxt_s.txw_pend = 1'b0;
      nxt_s.apb_rd_pend = 1'b0;
      nxt_s.ovr = 1'b0;
      nxt_s.unr = 1'b0;
    end

    // ==============================================================
    // Events, sticky status, interrupt and DMA request
    nxt_s.rx_lvl_prev = rx_lvl;
    nxt_s.tx_lvl_prev = tx_lvl;
    nxt_s.err_prev = s_ff.ovr || s_ff.unr;
    st_set[`SDBT_ST_RXRDY] = rx_lvl && !s_ff.rx_lvl_prev;
    st_set[`SDBT_ST_TXRDY] = tx_lvl && !s_ff.tx_lvl_prev;
    st_set[`SDBT_ST_ERR] = (s_ff.ovr || s_ff.unr) && !s_ff.err_prev;
    // A set landing with the read-clear wins
    nxt_s.status = (s_ff.status & ~st_clr) | st_set;
    nxt_s.irq = |(nxt_s.status & s_ff.mask);
    nxt_s.dma_req = nxt_s.dma_act && (tx_dir ? tx_lvl : rx_lvl);

    // ==============================================================
    // Memory clock divider; divide value clamped so the rate stays within limit
    eff_div = (s_ff.clk_div < MIN_DIV) ? MIN_DIV : s_ff.clk_div;
    if (!s_ff.clk_en) begin
      nxt_s.clk_cnt = '0;
      nxt_s.mem_clk = 1'b0;
    end else if (s_ff.clk_cnt >= eff_div) begin
      nxt_s.clk_cnt = '0;
      nxt_s.mem_clk = !s_ff.mem_clk;
    end else begin
      nxt_s.clk_cnt = s_ff.clk_cnt + 8'h01;
    end
  end

  // ==============================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.lstate <= SDBT_L_IDLE;
      s_ff.blen <= `SDBT_BLEN_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign irq = s_ff.irq;
  assign dma_req = s_ff.dma_req;
  assign mem_clk = s_ff.mem_clk;
  assign card_dat_o = s_ff.dat_o;
  assign card_dat_oe = s_ff.dat_oe;

endmodule

// File: sdbt_consts.svh
// Offsets, field positions, reset values and timing counts of the card block-transfer engine.
// Assumes a 200 MHz pclk and a 32-bit APB register bus.
`ifndef SDBT_CONSTS_SVH
`define SDBT_CONSTS_SVH

// ==============================================================
// Register byte offsets
`define SDBT_FIFO_CTL_OFS 8'h00
`define SDBT_MEMCLK_OFS 8'h04
`define SDBT_PSTAT_OFS 8'h08
`define SDBT_SSTAT_OFS 8'h0c
`define SDBT_MASK_OFS 8'h10
`define SDBT_BLEN_OFS 8'h14
`define SDBT_NBLK_OFS 8'h18
`define SDBT_BDONE_OFS 8'h1c
`define SDBT_RXDATA_OFS 8'h20
`define SDBT_TXDATA_OFS 8'h24
`define SDBT_CMDLO_OFS 8'h28
`define SDBT_CMDHI_OFS 8'h2c
`define SDBT_ARGLO_OFS 8'h30
`define SDBT_ARGHI_OFS 8'h34

// ==============================================================
// Field positions
`define SDBT_FC_FLUSH 0
`define SDBT_FC_DIR 1
`define SDBT_FC_THR 2
`define SDBT_FC_AW_LO 3
`define SDBT_CL_DATA 6
`define SDBT_CH_KICK 0
`define SDBT_CH_DMAMODE 1
`define SDBT_MC_EN 8
`define SDBT_ST_DONE 0
`define SDBT_ST_RXRDY 1
`define SDBT_ST_TXRDY 2
`define SDBT_ST_ERR 3

// ==============================================================
// Reset values, codes and timing
`define SDBT_BLEN_RST 16'h0200
`define SDBT_STOP_IDX 6'h0c
`define SDBT_FIFO_AW 4
`define SDBT_THR0_WORDS 5'h04
`define SDBT_THR1_WORDS 5'h08
`define SDBT_PCLK_MHZ 200
`define SDBT_MEMCLK_MAX_MHZ 50
`define SDBT_MEMCLK_MIN_DIV ((`SDBT_PCLK_MHZ + 2 * `SDBT_MEMCLK_MAX_MHZ - 1) / (2 * `SDBT_MEMCLK_MAX_MHZ) - 1)

`endif

// File: sdbt_pkg.sv
// Types of the card block-transfer engine: link states and the state record of all but the FIFO word store.
// Assumes sdbt_consts.svh sits in the include path.
`include "sdbt_consts.svh"

package sdbt_pkg;

  // ==============================================================
  // Link sequencer states
  typedef enum logic [5:0] {
    SDBT_L_IDLE = 6'h01,
    SDBT_L_RX_START = 6'h02,
    SDBT_L_RX_DATA = 6'h04,
    SDBT_L_TX_START = 6'h08,
    SDBT_L_TX_DATA = 6'h10,
    SDBT_L_TX_END = 6'h20
  } sdbt_lstate_t;

  // ==============================================================
  // APB request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sdbt_apb_req_t;

  // ==============================================================
  // All state of the engine except the FIFO word store
  typedef struct packed {
    logic [4:0] fifo_ctl;
    logic [7:0] clk_div;
    logic clk_en;
    logic [7:0] clk_cnt;
    logic mem_clk;
    logic [3:0] mask;
    logic [3:0] status;
    logic [15:0] blen;
    logic [15:0] nblk;
    logic [15:0] blk_done;
    logic [15:0] arg_lo;
    logic [15:0] arg_hi;
    logic [5:0] cmd_idx;
    logic dma_mode;
    logic dma_act;
    logic ovr;
    logic unr;
    sdbt_lstate_t lstate;
    logic [18:0] bitcnt;
    logic [31:0] shreg;
    logic txw_valid;
    logic txw_pend;
    logic apb_rd_pend;
    logic [`SDBT_FIFO_AW:0] wr_ptr;
    logic [`SDBT_FIFO_AW:0] rd_ptr;
    logic lclk_s1;
    logic lclk_s2;
    logic lclk_prev;
    logic dat_s1;
    logic dat_s2;
    logic rx_lvl_prev;
    logic tx_lvl_prev;
    logic err_prev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic dma_req;
    logic dat_o;
    logic dat_oe;
  } sdbt_state_t;

endpackage

// File: sdbt_fifo_mem.sv
// Word store of the data FIFO: one write port, one read port with registered read data.
// Assumes the caller keeps the pointers and never reads and writes beyond DEPTH words.
`timescale 1ns/1ps

module sdbt_fifo_mem #(
  parameter int AW = 4,
  parameter int DW = 32
) (
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  initial begin
    if (AW < 3 || DW != 32) begin
      $error("sdbt_fifo_mem: AW must be at least 3 and DW 32");
    end
  end

  // ==============================================================
  // No reset on the array; contents are only meaningful behind the pointers
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule

// File: sdbt_monitor.sv
// Port checker of the card block-transfer engine.
// Assumes an APB master that holds each request until pready is seen high.
`timescale 1ns/1ps
`include "sdbt_consts.svh"

module sdbt_monitor #(
  parameter int FIFO_AW = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic dma_req,
  input wire logic mem_clk,
  input wire logic link_clk,
  input wire logic card_dat_i,
  input wire logic card_dat_o,
  input wire logic card_dat_oe
);
  // ==============================================================
  // Helper state
  logic acc;
  logic kicked_ff;
  assign acc = psel && penable && !pready;
  // A DMA request before software armed a DMA mode would corrupt memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kicked_ff <= 1'b0;
    end else if (acc && pwrite && paddr == `SDBT_CMDHI_OFS && pwdata[1:0] != 2'h0) begin
      kicked_ff <= 1'b1;
    end
  end

  // ==============================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  answer_once_a: assert property (acc |=> pready ##1 !pready)
    else $error("access not answered in one cycle");
  bad_addr_a: assert property (acc |=> pslverr == (paddr > `SDBT_ARGHI_OFS || paddr[1:0] != 2'h0))
    else $error("error response does not match address");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response carries data");
  mask_off_a: assert property (acc && pwrite && paddr == `SDBT_MASK_OFS && pwdata[3:0] == 4'h0 |-> ##2 !irq)
    else $error("interrupt stays up with all sources masked");
  dma_kick_a: assert property ($rose(dma_req) |-> kicked_ff)
    else $error("dma request without kick");
  clk_high_a: assert property ($rose(mem_clk) |=> mem_clk)
    else $error("memory clock high phase too short");
  clk_low_a: assert property ($fell(mem_clk) |=> !mem_clk)
    else $error("memory clock low phase too short");
  start_bit_a: assert property ($rose(card_dat_oe) |-> !card_dat_o)
    else $error("frame does not open with a zero");
  end_bit_a: assert property ($fell(card_dat_oe) |-> $past(card_dat_o))
    else $error("frame does not close with a one");
  dat_hold_a: assert property (card_dat_oe && $changed(card_dat_o) |-> !link_clk)
    else $error("data changed while link clock high");
endmodule

bind sdbt_top sdbt_monitor #(.FIFO_AW(FIFO_AW)) i_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .dma_req(dma_req),
  .mem_clk(mem_clk), .link_clk(link_clk), .card_dat_i(card_dat_i), .card_dat_o(card_dat_o),
  .card_dat_oe(card_dat_oe)
);

// File: sdbt_card_model.sv
// Card-side model: runs the link clock in frames, sends one block, captures written frames.
// Assumes the bench raises run around each frame and pulses send once the engine waits.
`timescale 1ns/1ps

module sdbt_card_model (
  input wire logic run,
  input wire logic send,
  input wire logic [15:0] nbits,
  input wire logic [63:0] pat,
  input wire logic card_dat_o,
  input wire logic card_dat_oe,
  output logic link_clk,
  output logic card_dat_i,
  output logic [65:0] cap
);
  // ==============================================================
  // Link clock and data
  int idx;
  logic busy;
  initial begin
    link_clk = 1'b0;
    card_dat_i = 1'b1;
    busy = 1'b0;
    idx = 0;
    cap = '0;
    #13;
    // Clock stands still between frames
    forever #40 link_clk = run ? ~link_clk : 1'b0;
  end
  always @(posedge send) begin
    busy = 1'b1;
    idx = -1;
  end
  // Block length set by the bench to match the engine
  always @(negedge link_clk) begin
    if (busy && idx < int'(nbits)) begin
      card_dat_i = (idx < 0) ? 1'b0 : pat[63 - (idx % 64)];
      idx++;
    end else begin
      // Released line returns to its pull-up level
      busy = 1'b0;
      card_dat_i = 1'b1;
    end
  end
  always @(posedge link_clk) begin
    if (card_dat_oe === 1'b1) begin
      cap = {cap[64:0], card_dat_o};
    end
  end
endmodule

// File: sd_card_block_transfer_tb.sv
// Self-checking bench of the card block-transfer engine over APB and the card link.
// Assumes sdbt_top, the bound monitor and sdbt_card_model are compiled ahead of it.
`timescale 1ns/1ps
`include "sdbt_consts.svh"

module sd_card_block_transfer_tb;
  // ==============================================================
  // Signals and instances
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, dma_req, mem_clk;
  logic link_clk, card_dat_i, card_dat_o, card_dat_oe, run, send, er;
  logic [7:0] paddr;
  logic [15:0] nbits;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] pat;
  logic [65:0] cap;
  int mismatches, cmp_count, n, n1;
  sdbt_top i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .dma_req(dma_req),
    .mem_clk(mem_clk), .link_clk(link_clk), .card_dat_i(card_dat_i), .card_dat_o(card_dat_o),
    .card_dat_oe(card_dat_oe)
  );
  sdbt_card_model i_card (
    .run(run), .send(send), .nbits(nbits), .pat(pat), .card_dat_o(card_dat_o), .card_dat_oe(card_dat_oe),
    .link_clk(link_clk), .card_dat_i(card_dat_i), .cap(cap)
  );

  // ==============================================================
  // Tasks
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Waits an edge first so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb answer", 32'h1, {31'h0, pready});
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return irq;
      1: return dma_req;
      2: return !dma_req;
      3: return !card_dat_oe;
      4: return !irq;
      5: return mem_clk;
      default: return !mem_clk;
    endcase
  endfunction
  task automatic wt(input int w, input int lim);
    n = 0;
    cmp_count++;
    while (sel(w) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (sel(w) !== 1'b1) begin
      mismatches++;
      $display("mismatch wait %0d expected 1 seen 0", w);
    end
  endtask
  function automatic logic [31:0] exp_word(input int j);
    return (j % 2) ? pat[31:0] : pat[63:32];
  endfunction
  // Flush, threshold and direction set before each start; short whole-word lengths keep runs brief
  task automatic start_rx(input logic [31:0] blen, input logic [31:0] cnt, input logic [31:0] msk);
    apb(1'b1, `SDBT_FIFO_CTL_OFS, 32'h1);
    apb(1'b1, `SDBT_FIFO_CTL_OFS, 32'h0);
    apb(1'b1, `SDBT_BLEN_OFS, blen);
    apb(1'b1, `SDBT_NBLK_OFS, cnt);
    apb(1'b1, `SDBT_MASK_OFS, msk);
    pat <= {$urandom, $urandom};
    nbits <= 16'(blen[12:0] * 8);
    apb(1'b1, `SDBT_CMDLO_OFS, 32'h52);
    run <= 1'b1;
    send <= 1'b1;
    @(posedge pclk);
    send <= 1'b0;
    wt(0, 60000);
  endtask

  // ==============================================================
  // Clock, watchdog and tests
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #500000;
    mismatches++;
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, run, send, presetn} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    nbits = 16'h0;
    pat = 64'h0;
    mismatches = 0;
    cmp_count = 0;
    void'($urandom(51694));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("block length", `SDBT_BLEN_OFS, 32'h200);
    rdchk("secondary", `SDBT_SSTAT_OFS, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    $display("reset test done");
    apb(1'b1, `SDBT_FIFO_CTL_OFS, 32'h3);
    apb(1'b1, `SDBT_TXDATA_OFS, $urandom);
    rdchk("flushed", `SDBT_SSTAT_OFS, 32'h1);
    apb(1'b1, `SDBT_FIFO_CTL_OFS, 32'h2);
    chk("dma idle", 32'h0, {31'h0, dma_req});
    apb(1'b1, `SDBT_CMDHI_OFS, 32'h1);
    wt(1, 10);
    repeat (10) apb(1'b1, `SDBT_TXDATA_OFS, $urandom);
    apb(1'b1, `SDBT_FIFO_CTL_OFS, 32'h6);
    wt(2, 10);
    apb(1'b1, `SDBT_FIFO_CTL_OFS, 32'h2);
    wt(1, 10);
    repeat (7) apb(1'b1, `SDBT_TXDATA_OFS, $urandom);
    rdchk("full overrun", `SDBT_SSTAT_OFS, 32'ha);
    apb(1'b1, `SDBT_FIFO_CTL_OFS, 32'h3);
    apb(1'b1, `SDBT_FIFO_CTL_OFS, 32'h2);
    rdchk("reflushed", `SDBT_SSTAT_OFS, 32'h1);
    $display("fifo test done");
    pat = {$urandom, $urandom};
    apb(1'b1, `SDBT_BLEN_OFS, 32'h8);
    apb(1'b1, `SDBT_NBLK_OFS, 32'h1);
    apb(1'b1, `SDBT_TXDATA_OFS, pat[63:32]);
    apb(1'b1, `SDBT_TXDATA_OFS, pat[31:0]);
    apb(1'b1, `SDBT_MASK_OFS, 32'h1);
    apb(1'b1, `SDBT_CMDLO_OFS, 32'h59);
    apb(1'b1, `SDBT_CMDHI_OFS, 32'h1);
    wt(1, 10);
    run <= 1'b1;
    wt(0, 20000);
    wt(3, 2000);
    run <= 1'b0;
    chk("dma done", 32'h0, {31'h0, dma_req});
    chk("tx high", pat[63:32], cap[64:33]);
    chk("tx low", pat[31:0], cap[32:1]);
    chk("tx frame", 32'h1, {30'h0, cap[65], cap[0]});
    apb(1'b1, `SDBT_MASK_OFS, 32'h0);
    wt(4, 10);
    apb(1'b0, `SDBT_PSTAT_OFS, 32'h0);
    chk("tx done", 32'h1, rd & 32'h1);
    rdchk("status cleared", `SDBT_PSTAT_OFS, 32'h0);
    rdchk("blocks", `SDBT_BDONE_OFS, 32'h1);
    $display("write test done");
    // Configuration read, then switch status read, each drained after the clock is stopped
    for (int i = 0; i < 2; i++) begin
      start_rx(i ? 32'h40 : 32'h8, 32'h1, i ? 32'h2 : 32'h1);
      if (i) begin
        apb(1'b0, `SDBT_PSTAT_OFS, 32'h0);
        chk("rx ready", 32'h2, rd & 32'h2);
        apb(1'b1, `SDBT_MASK_OFS, 32'h1);
        wt(0, 60000);
      end
      run <= 1'b0;
      apb(1'b0, `SDBT_PSTAT_OFS, 32'h0);
      chk("rx done", 32'h1, rd & 32'h1);
      for (int j = 0; j < (i ? 16 : 2); j++) begin
        apb(1'b0, `SDBT_RXDATA_OFS, 32'h0);
        chk("rx word", exp_word(j), rd);
      end
      rdchk("drained", `SDBT_SSTAT_OFS, 32'h1);
    end
    $display("read test done");
    apb(1'b1, `SDBT_CMDHI_OFS, 32'h2);
    start_rx(32'h10, 32'h0, 32'h2);
    chk("rx dma", 32'h1, {31'h0, dma_req});
    apb(1'b0, `SDBT_PSTAT_OFS, 32'h0);
    chk("no auto end", 32'h0, rd & 32'h1);
    rdchk("busy", `SDBT_SSTAT_OFS, 32'h4);
    apb(1'b1, `SDBT_CMDLO_OFS, {26'h0, `SDBT_STOP_IDX});
    rdchk("stopped", `SDBT_SSTAT_OFS, 32'h0);
    chk("dma stopped", 32'h0, {31'h0, dma_req});
    run <= 1'b0;
    $display("stop test done");
    // Divide value 0 lies below the limit and must be clamped
    apb(1'b1, `SDBT_MEMCLK_OFS, 32'h100);
    wt(6, 50);
    wt(5, 50);
    wt(6, 50);
    n1 = n;
    wt(5, 50);
    chk("clock period", 2 * (`SDBT_MEMCLK_MIN_DIV + 1), n1 + n);
    $display("clock test done");
    stop_test();
  end
endmodule
